// File: flash_pkg.sv
// Shared constants and types for the serial flash command core
package flash_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned TIMER_W = 27;

  localparam int unsigned LOCKOUT_MIN_US   = 1000;
  localparam int unsigned LOCKOUT_MAX_US   = 10000;
  localparam int unsigned STATUS_WRITE_US  = 5000;
  localparam int unsigned PAGE_PROGRAM_US  = 1400;
  localparam int unsigned SECTOR_ERASE_US  = 60000;
  localparam int unsigned BLOCK_ERASE_US   = 1000000;
  localparam int unsigned CHIP_ERASE_US    = 3500000;
  localparam int unsigned SLEEP_ENTRY_NS   = 3000;
  localparam int unsigned WAKE_SIG_NS      = 1800;
  localparam int unsigned WAKE_PLAIN_NS    = 3000;

  // Least times round up, longest round down
  localparam int unsigned LOCKOUT_CYC      = LOCKOUT_MIN_US * CLK_MHZ;
  localparam int unsigned STATUS_WRITE_CYC = STATUS_WRITE_US * CLK_MHZ;
  localparam int unsigned PAGE_PROGRAM_CYC = PAGE_PROGRAM_US * CLK_MHZ;
  localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_US * CLK_MHZ;
  localparam int unsigned BLOCK_ERASE_CYC  = BLOCK_ERASE_US * CLK_MHZ;
  localparam int unsigned CHIP_ERASE_CYC   = CHIP_ERASE_US * CLK_MHZ;
  // Select rise reaches the timers this late
  localparam int unsigned SEL_LAT_CYC = 4;
  localparam logic [TIMER_W-1:0] SLEEP_ENTRY_CYC = TIMER_W'(SLEEP_ENTRY_NS * CLK_MHZ / 1000 - SEL_LAT_CYC);
  localparam logic [TIMER_W-1:0] WAKE_SIG_CYC    = TIMER_W'(WAKE_SIG_NS * CLK_MHZ / 1000 - SEL_LAT_CYC);
  localparam logic [TIMER_W-1:0] WAKE_PLAIN_CYC  = TIMER_W'(WAKE_PLAIN_NS * CLK_MHZ / 1000 - SEL_LAT_CYC);

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_ID       = 8'h9f;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0b;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE_A = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE_B = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hc7;
  localparam logic [7:0] OP_DEEP_SLEEP    = 8'hb9;
  localparam logic [7:0] OP_WAKE          = 8'hab;
  localparam logic [7:0] OP_MAKER_DEV_ID  = 8'h90;

  // Identification values are arbitrary
  localparam logic [7:0] MAKER_CODE  = 8'h5a;
  localparam logic [7:0] DEVICE_CODE = 8'h3c;
  localparam logic [7:0] MEM_TYPE    = 8'h20;

  // ==========================================================================
  // Status and array layout
  localparam int unsigned WIP_BIT      = 0;
  localparam int unsigned WEL_BIT      = 1;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  STATUS_WMASK = 8'h9c;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam int unsigned MEM_AW       = 19;
  localparam int unsigned PAGE_AW      = 8;
  localparam int unsigned PG_W         = MEM_AW - PAGE_AW;
  localparam int unsigned PAGES        = 1 << PG_W;
  localparam int unsigned SECTOR_SHIFT = 4;
  localparam int unsigned BLOCK_SHIFT  = 8;

  typedef enum logic [5:0] {
    M_CMD      = 6'b000001,
    M_ADDR     = 6'b000010,
    M_DUMMY    = 6'b000100,
    M_DATA_IN  = 6'b001000,
    M_DATA_OUT = 6'b010000,
    M_IGNORE   = 6'b100000
  } mode_t;

  typedef enum logic [4:0] {
    K_STATUS = 5'b00001,
    K_PROG   = 5'b00010,
    K_SECTOR = 5'b00100,
    K_BLOCK  = 5'b01000,
    K_CHIP   = 5'b10000
  } kind_t;

endpackage

// File: spi_link_if.sv
// Byte-level link between the serial shifter and the command core
`timescale 1ns/1ns
interface spi_link_if;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       frame_end;
  logic       aligned;
  logic [7:0] tx_byte;
  logic       tx_load;
  logic       talk;

  modport shifter (output rx_byte, output rx_valid, output frame_end, output aligned,
                   input tx_byte, input tx_load, input talk);
  modport core    (input rx_byte, input rx_valid, input frame_end, input aligned,
                   output tx_byte, output tx_load, output talk);
endinterface

// File: spi_shifter.sv
// Mode 0/3 serial shifter: pin synchronisers, byte assembly and output shifting
`timescale 1ns/1ns
module spi_shifter
  import flash_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic cs_n_i,
  input  wire logic sclk_i,
  input  wire logic si_i,
  output logic      so_o,
  output logic      so_oe_o,
  spi_link_if.shifter lk
);

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [1:0] si_s;
    logic [7:0] rx_sr;
    logic [2:0] bitc;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       frame_end;
    logic [7:0] tx_sr;
    logic       fresh;
    logic       so;
    logic       oe;
  } shf_t;

  shf_t s_r;
  shf_t s_nxt;
  logic sel;
  logic rise;
  logic fall;

  // ==========================================================================
  // Next state
  // Edges are seen only through the 20 MHz samples, so the serial clock must
  // stay well below a quarter of the system clock in this model.
  always_comb begin
    s_nxt           = s_r;
    s_nxt.cs_s      = {s_r.cs_s[1:0], cs_n_i};
    s_nxt.sck_s     = {s_r.sck_s[1:0], sclk_i};
    s_nxt.si_s      = {s_r.si_s[0], si_i};
    s_nxt.rx_valid  = 1'b0;
    s_nxt.frame_end = s_r.cs_s[1] & ~s_r.cs_s[2];
    // Lags frame_end so the bit count is still seen
    sel  = ~s_r.cs_s[2];
    rise = sel & s_r.sck_s[1] & ~s_r.sck_s[2];
    fall = sel & ~s_r.sck_s[1] & s_r.sck_s[2];
    if (!sel) begin
      s_nxt.bitc  = 3'h0;
      s_nxt.fresh = 1'b0;
    end else if (rise) begin
      s_nxt.rx_sr = {s_r.rx_sr[6:0], s_r.si_s[1]};
      s_nxt.bitc  = s_r.bitc + 3'h1;
      if (s_r.bitc == 3'h7) begin
        s_nxt.rx_byte  = {s_r.rx_sr[6:0], s_r.si_s[1]};
        s_nxt.rx_valid = 1'b1;
      end
    end
    // A load holds off one falling edge so its top bit appears first
    if (lk.tx_load) begin
      s_nxt.tx_sr = lk.tx_byte;
      s_nxt.fresh = 1'b1;
    end else if (fall) begin
      if (s_r.fresh) begin
        s_nxt.fresh = 1'b0;
      end else begin
        s_nxt.tx_sr = {s_r.tx_sr[6:0], 1'b0};
      end
    end
    s_nxt.so = s_nxt.tx_sr[7];
    s_nxt.oe = sel & lk.talk;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{cs_s: 3'h7, sck_s: 3'h0, si_s: 2'h0, rx_sr: 8'h00, bitc: 3'h0, rx_byte: 8'h00,
               rx_valid: 1'b0, frame_end: 1'b0, tx_sr: 8'h00, fresh: 1'b0, so: 1'b0, oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lk.rx_byte   = s_r.rx_byte;
  assign lk.rx_valid  = s_r.rx_valid;
  assign lk.frame_end = s_r.frame_end;
  assign lk.aligned   = (s_r.bitc == 3'h0);
  assign so_o         = s_r.so;
  assign so_oe_o      = s_r.oe;

endmodule

// File: flash_core.sv
// Serial flash command core: decode, array model, internal cycle timing
// What this block does, and what its host must do
// R01 - Opcode 20h starts 4K sector erase
// R02 - Opcodes 52h and D8h both erase block
// R03 - Opcodes 60h and C7h both erase chip
// R04 - Address 00h maker first; 01h device first
// R05 - Array starts with every byte FFh
// R06 - Status register starts at 00h
// R07 - Write lockout 1 to 10 ms after power-up
// R08 - Host waits 10 us before first select
// R09 - Deep sleep reached within 3 us
// R10 - Wake within release delay, 1.8 us signature
// R11 - Status write cycle within 15 ms
// R12 - Page program 1.4 ms typical, 5 max
// R13 - Sector erase 60 ms typical, 120 max
// R14 - Block erase 1 s typical, 2 max
// R15 - Chip erase 3.5 s typical, 7.5 max
// R16 - Host clocks plain read at most 33 MHz
// R17 - Host clocks other commands up to 70 MHz
// R18 - Write-type commands ignored during lockout
// R19 - Power-up in standby, enable latch cleared
// R20 - Busy flag set during every internal cycle
`timescale 1ns/1ns
module flash_core
  import flash_pkg::*;
#(
  parameter logic [TIMER_W-1:0] LOCKOUT_CYCLES = TIMER_W'(LOCKOUT_CYC),
  parameter logic [TIMER_W-1:0] STATUS_CYCLES  = TIMER_W'(STATUS_WRITE_CYC),
  parameter logic [TIMER_W-1:0] PROGRAM_CYCLES = TIMER_W'(PAGE_PROGRAM_CYC),
  parameter logic [TIMER_W-1:0] SECTOR_CYCLES  = TIMER_W'(SECTOR_ERASE_CYC),
  parameter logic [TIMER_W-1:0] BLOCK_CYCLES   = TIMER_W'(BLOCK_ERASE_CYC),
  parameter logic [TIMER_W-1:0] CHIP_CYCLES    = TIMER_W'(CHIP_ERASE_CYC),
  parameter logic [7:0]         MAKER_ID       = MAKER_CODE,
  parameter logic [7:0]         DEVICE_ID      = DEVICE_CODE
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic cs_n_i,
  input  wire logic sclk_i,
  input  wire logic si_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      busy_o,
  output logic      asleep_o,
  output logic      write_locked_o
);

  typedef struct packed {
    mode_t              mode;
    logic [7:0]         op;
    logic [23:0]        addr;
    logic [1:0]         cnt;
    logic               armed;
    logic               sig_read;
    logic [7:0]         status;
    logic [7:0]         wsr_data;
    kind_t              kind;
    logic [TIMER_W-1:0] lock_cnt;
    logic [TIMER_W-1:0] busy_cnt;
    logic [TIMER_W-1:0] pm_cnt;
    logic               pm_wake;
    logic               deep;
    logic               sweeping;
    logic [PAGE_AW-1:0] ptr;
    logic [PG_W-1:0]    pg;
    logic [PAGES-1:0]   blank;
    logic [255:0]       pvalid;
    logic [7:0]         tx_byte;
    logic               tx_load;
    logic               talk;
    logic               busy;
    logic               asleep;
    logic               locked;
  } core_t;

  core_t s_r;
  core_t n;
  spi_link_if lk ();

  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [7:0] pbuf [0:255];

  logic              mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic              pbuf_we;
  logic [7:0]        pbuf_wa;
  logic [7:0]        pbuf_wd;
  logic [MEM_AW-1:0] rd_a;
  logic [7:0]        rd_byte;
  logic [MEM_AW-1:0] sw_a;
  logic [7:0]        sw_old;
  logic [7:0]        b;
  logic              locked;
  logic              write_enable_latch;

  spi_shifter u_shifter (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .cs_n_i  (cs_n_i),
    .sclk_i  (sclk_i),
    .si_i    (si_i),
    .so_o    (so_o),
    .so_oe_o (so_oe_o),
    .lk      (lk.shifter)
  );

  // A blank page reads as erased whatever the array holds, so erase never
  // has to sweep the array and power-up needs no fill pass.
  assign rd_a    = s_r.addr[MEM_AW-1:0];
  assign rd_byte = s_r.blank[rd_a[MEM_AW-1:PAGE_AW]] ? ERASED_BYTE : mem[rd_a];  // R05
  assign sw_a    = {s_r.pg, s_r.ptr};
  assign sw_old  = s_r.blank[s_r.pg] ? ERASED_BYTE : mem[sw_a];
  assign b       = lk.rx_byte;
  assign locked  = (s_r.lock_cnt != '0);
  assign write_enable_latch     = s_r.status[WEL_BIT];

  // ==========================================================================
  // Next state
  always_comb begin
    n         = s_r;
    n.tx_load = 1'b0;
    mem_we    = 1'b0;
    mem_wa    = sw_a;
    mem_wd    = sw_old & (s_r.pvalid[s_r.ptr] ? pbuf[s_r.ptr] : ERASED_BYTE);
    pbuf_we   = 1'b0;
    pbuf_wa   = s_r.addr[7:0];
    pbuf_wd   = b;

    if (locked) begin
      n.lock_cnt = s_r.lock_cnt - TIMER_W'(1);  // R07
    end

    // Power state timers start at deselect
    if (s_r.pm_cnt != '0) begin
      n.pm_cnt = s_r.pm_cnt - TIMER_W'(1);
      if (s_r.pm_cnt == TIMER_W'(1)) begin
        n.deep = ~s_r.pm_wake;  // R09 R10
      end
    end

    // Internal cycle: the page copy runs in the first 256 cycles of the program time
    if (s_r.sweeping) begin
      mem_we = 1'b1;
      n.ptr  = s_r.ptr + PAGE_AW'(1);
      if (s_r.ptr == '1) begin
        n.sweeping       = 1'b0;
        n.blank[s_r.pg]  = 1'b0;
      end
    end
    if (s_r.status[WIP_BIT]) begin
      n.busy_cnt = s_r.busy_cnt - TIMER_W'(1);
      if (s_r.busy_cnt == TIMER_W'(1)) begin
        n.status[WIP_BIT] = 1'b0;  // R20
        n.status[WEL_BIT] = 1'b0;
        case (s_r.kind)
          K_STATUS: n.status = (s_r.status & ~STATUS_WMASK) & ~8'h03 | (s_r.wsr_data & STATUS_WMASK);  // R11
          K_SECTOR: begin
            for (int p = 0; p < PAGES; p++) begin
              if ((p >> SECTOR_SHIFT) == (int'(s_r.pg) >> SECTOR_SHIFT)) n.blank[p] = 1'b1;  // R13
            end
          end
          K_BLOCK: begin
            for (int p = 0; p < PAGES; p++) begin
              if ((p >> BLOCK_SHIFT) == (int'(s_r.pg) >> BLOCK_SHIFT)) n.blank[p] = 1'b1;  // R14
            end
          end
          K_CHIP:  n.blank = '1;  // R15
          default: n.blank = s_r.blank;
        endcase
      end
    end

    // Byte received from the host
    if (lk.rx_valid) begin
      case (s_r.mode)
        M_CMD: begin
          n.op       = b;
          n.cnt      = 2'h0;
          n.armed    = 1'b0;
          n.sig_read = 1'b0;
          n.mode     = M_IGNORE;
          if (s_r.deep || s_r.pm_cnt != '0) begin
            if (b == OP_WAKE && s_r.deep) begin
              n.mode  = M_ADDR;
              n.armed = 1'b1;
            end
          end else if (s_r.status[WIP_BIT]) begin
            if (b == OP_STATUS_READ) begin
              n.mode = M_DATA_OUT;
              n.tx_byte = s_r.status;
              n.tx_load = 1'b1;
              n.talk = 1'b1;
            end
          end else begin
            case (b)
              OP_READ, OP_FAST_READ, OP_MAKER_DEV_ID, OP_PAGE_PROGRAM,
              OP_SECTOR_ERASE, OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B: n.mode = M_ADDR;  // R01 R02
              OP_WAKE: n.mode = M_ADDR;
              OP_STATUS_READ, OP_READ_ID: begin
                n.mode    = M_DATA_OUT;
                n.tx_byte = (b == OP_READ_ID) ? MAKER_ID : s_r.status;
                n.tx_load = 1'b1;
                n.talk    = 1'b1;
              end
              OP_STATUS_WRITE: n.mode = M_DATA_IN;
              OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B,
              OP_DEEP_SLEEP: n.armed = 1'b1;  // R03
              default: n.armed = 1'b0;
            endcase
          end
        end
        M_ADDR: begin
          n.addr = {s_r.addr[15:0], b};
          n.cnt  = s_r.cnt + 2'h1;
          if (s_r.cnt == 2'h2) begin
            n.mode = M_IGNORE;
            n.armed = 1'b1;
            if (s_r.op == OP_FAST_READ) begin
              n.mode = M_DUMMY;
            end else if (s_r.op == OP_PAGE_PROGRAM) begin
              n.mode   = M_DATA_IN;
              n.armed  = 1'b0;
              n.pvalid = '0;
            end else if (s_r.op == OP_READ || s_r.op == OP_MAKER_DEV_ID || s_r.op == OP_WAKE) begin
              n.mode = M_DATA_OUT;
              n.talk = 1'b1;
              n.tx_load = 1'b1;
              n.sig_read = (s_r.op == OP_WAKE);
              if (s_r.op == OP_WAKE) begin
                n.tx_byte = DEVICE_ID;
              end else if (s_r.op == OP_MAKER_DEV_ID) begin
                n.tx_byte = b[0] ? DEVICE_ID : MAKER_ID;  // R04
              end else begin
                n.tx_byte = s_r.blank[s_r.addr[MEM_AW-9:PAGE_AW-8]] ? ERASED_BYTE
                          : mem[{s_r.addr[MEM_AW-9:0], b}];
                n.addr    = {s_r.addr[15:0], b} + 24'h1;
              end
            end
          end
        end
        M_DUMMY: begin
          n.mode    = M_DATA_OUT;
          n.talk    = 1'b1;
          n.tx_byte = rd_byte;
          n.tx_load = 1'b1;
          n.addr    = s_r.addr + 24'h1;
        end
        M_DATA_OUT: begin
          n.tx_load = 1'b1;
          n.cnt     = s_r.cnt + 2'h1;
          case (s_r.op)
            OP_STATUS_READ:  n.tx_byte = s_r.status;
            OP_WAKE:         n.tx_byte = DEVICE_ID;
            OP_MAKER_DEV_ID: n.tx_byte = (s_r.tx_byte == MAKER_ID) ? DEVICE_ID : MAKER_ID;  // R04
            OP_READ_ID:      n.tx_byte = (s_r.cnt == 2'h0) ? MEM_TYPE : DEVICE_ID;
            default: begin
              n.tx_byte = rd_byte;
              n.addr    = s_r.addr + 24'h1;
            end
          endcase
        end
        M_DATA_IN: begin
          n.armed = 1'b1;
          if (s_r.op == OP_PAGE_PROGRAM) begin
            pbuf_we                  = 1'b1;
            n.pvalid[s_r.addr[7:0]]  = 1'b1;
            n.addr[7:0]              = s_r.addr[7:0] + 8'h1;
          end else begin
            n.wsr_data = b;
            n.mode     = M_IGNORE;
          end
        end
        default: n.mode = M_IGNORE;
      endcase
    end

    // Deselect commits the command; a part byte cancels it
    if (lk.frame_end) begin
      n.mode = M_CMD;
      n.talk = 1'b0;
      n.armed = 1'b0;
      if (s_r.armed && lk.aligned) begin
        case (s_r.op)
          OP_WRITE_ENABLE:  if (!locked && !s_r.status[WIP_BIT] && !s_r.deep) n.status[WEL_BIT] = 1'b1;  // R18
          OP_WRITE_DISABLE: if (!s_r.status[WIP_BIT]) n.status[WEL_BIT] = 1'b0;
          OP_DEEP_SLEEP: begin
            n.pm_cnt  = SLEEP_ENTRY_CYC;  // R09
            n.pm_wake = 1'b0;
          end
          OP_WAKE: begin
            if (s_r.deep) begin
              n.pm_cnt  = s_r.sig_read ? WAKE_SIG_CYC : WAKE_PLAIN_CYC;  // R10
              n.pm_wake = 1'b1;
            end
          end
          default: begin
            if (write_enable_latch && !locked && !s_r.status[WIP_BIT]) begin  // R18
              n.status[WIP_BIT] = 1'b1;  // R20
              n.pg = s_r.addr[MEM_AW-1:PAGE_AW];
              case (s_r.op)
                OP_STATUS_WRITE: begin
                  n.kind = K_STATUS;
                  n.busy_cnt = STATUS_CYCLES;  // R11
                end
                OP_PAGE_PROGRAM: begin
                  n.kind = K_PROG;
                  n.busy_cnt = PROGRAM_CYCLES;  // R12
                  n.sweeping = 1'b1;
                  n.ptr = '0;
                end
                OP_SECTOR_ERASE: begin
                  n.kind = K_SECTOR;
                  n.busy_cnt = SECTOR_CYCLES;  // R01 R13
                end
                OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B: begin
                  n.kind = K_BLOCK;
                  n.busy_cnt = BLOCK_CYCLES;  // R02 R14
                end
                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                  n.kind = K_CHIP;
                  n.busy_cnt = CHIP_CYCLES;  // R03 R15
                end
                default: n.status[WIP_BIT] = 1'b0;
              endcase
            end
          end
        endcase
      end
    end

    n.busy   = n.status[WIP_BIT];
    n.asleep = n.deep;
    n.locked = (n.lock_cnt != '0);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.mode     <= M_CMD;
      s_r.kind     <= K_STATUS;
      s_r.status   <= STATUS_RESET;  // R06 R19
      s_r.lock_cnt <= LOCKOUT_CYCLES;  // R07
      s_r.locked   <= 1'b1;
      s_r.blank    <= '1;  // R05
    end else begin
      s_r <= n;
    end
  end

  // Array contents are not reset; the blank map covers them
  always_ff @(posedge clock_i) begin
    if (mem_we) mem[mem_wa] <= mem_wd;  // R12
    if (pbuf_we) pbuf[pbuf_wa] <= pbuf_wd;
  end

  assign lk.tx_byte  = s_r.tx_byte;
  assign lk.tx_load  = s_r.tx_load;
  assign lk.talk     = s_r.talk;
  assign busy_o         = s_r.busy;
  assign asleep_o       = s_r.asleep;
  assign write_locked_o = s_r.locked;

endmodule

// File: flash_core_checker.sv
// Pin-level assertions for the flash command core
`timescale 1ns/1ns
module flash_core_checker
  import flash_pkg::*;
#(
  parameter logic [TIMER_W-1:0] LOCKOUT_CYCLES = 1,
  parameter logic [TIMER_W-1:0] LONGEST_CYCLES = 1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic busy_o,
  input wire logic asleep_o,
  input wire logic write_locked_o
);
  // ==========================================================================
  // Cycle counters: since reset, since deselect, busy length
  logic [TIMER_W-1:0] up_r;
  logic [TIMER_W-1:0] hi_r;
  logic [TIMER_W-1:0] bz_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      up_r <= '0;
      hi_r <= '0;
      bz_r <= '0;
    end else begin
      up_r <= up_r + 1'b1;
      hi_r <= cs_n_i ? hi_r + 1'b1 : '0;
      bz_r <= busy_o ? bz_r + 1'b1 : '0;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_reset_state;
    $fell(rst_i) |-> write_locked_o && !asleep_o && !busy_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
  property p_lock_early;
    $fell(write_locked_o) |-> up_r >= LOCKOUT_CYCLES - 1'b1;
  endproperty
  a_lock_early: assert property (p_lock_early) else $error("lockout too short");
  property p_lock_late;
    up_r > LOCKOUT_CYCLES + 2'd3 |-> !write_locked_o;
  endproperty
  a_lock_late: assert property (p_lock_late) else $error("lockout too long");
  property p_lock_idle;
    write_locked_o |-> !busy_o;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("write cycle during lockout");
  property p_sleep;
    $rose(asleep_o) |-> hi_r <= 60;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry late");
  property p_wake;
    $fell(asleep_o) |-> cs_n_i && hi_r <= 60;
  endproperty
  a_wake: assert property (p_wake) else $error("wake late");
  property p_busy_max;
    busy_o |-> bz_r <= LONGEST_CYCLES + 4'd8;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("internal cycle too long");
  property p_busy_min;
    $rose(busy_o) |-> busy_o [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy flag dropped early");
  c_sleep: cover property ($rose(asleep_o));
  c_busy: cover property ($fell(busy_o));
  c_talk: cover property ($rose(so_oe_o));
endmodule

bind flash_core flash_core_checker #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES),
  .LONGEST_CYCLES(CHIP_CYCLES > PROGRAM_CYCLES ? CHIP_CYCLES : PROGRAM_CYCLES)) chk (
  .clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .si_i(si_i), .so_o(so_o),
  .so_oe_o(so_oe_o), .busy_o(busy_o), .asleep_o(asleep_o), .write_locked_o(write_locked_o));

// File: spi_host_model.sv
// Host controller model driving the flash serial pins
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic clock_i,
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      si_o
);
  // ==========================================================================
  // Pin drive
  logic si_r;
  logic tog_r;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_r = 1'b0;
    tog_r = 1'b0;
  end
  // Released data line toggles so a stale bit never looks valid
  always @(posedge clock_i) tog_r <= ~tog_r;
  assign si_o = cs_n_o ? tog_r : si_r;
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  // Five cycles a half period: 2 MHz, far under either rate limit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_r = tx[i];
      tick(5);
      sclk_o = 1'b1;
      rx[i] = so_i;
      tick(5);
      sclk_o = 1'b0;
    end
  endtask
  task automatic frame(input int n, input logic [47:0] tx, output logic [15:0] rx);
    logic [7:0] b;
    tick(1);
    cs_n_o = 1'b0;
    tick(5);
    for (int k = n - 1; k >= 0; k--) begin
      xfer(tx[8*k +: 8], b);
      rx = {rx[7:0], b};
    end
    tick(5);
    cs_n_o = 1'b1;
    tick(10);
  endtask
endmodule

// File: tb_serial_flash_command_timing.sv
// Self-checking bench for the serial flash command core
`timescale 1ns/1ns
module tb_serial_flash_command_timing;
  import flash_pkg::*;
  localparam logic [TIMER_W-1:0] LK = 2000;
  localparam logic [TIMER_W-1:0] ST = 40;
  localparam logic [TIMER_W-1:0] PG = 300;
  localparam logic [TIMER_W-1:0] SE = 60;
  localparam logic [TIMER_W-1:0] BE = 80;
  localparam logic [TIMER_W-1:0] CE = 100;
  logic clock_i, rst_i, cs_n, sclk, si, so, so_oe, busy, asleep, locked, so_last, so_line;
  logic [15:0] rx;
  int num_errors, n_tests, since_rst, n;
  flash_core #(.LOCKOUT_CYCLES(LK), .STATUS_CYCLES(ST), .PROGRAM_CYCLES(PG), .SECTOR_CYCLES(SE),
    .BLOCK_CYCLES(BE), .CHIP_CYCLES(CE)) uut (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_o(so_oe), .busy_o(busy), .asleep_o(asleep),
    .write_locked_o(locked));
  spi_host_model host (.clock_i(clock_i), .so_i(so_line), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
  // ==========================================================================
  // Undriven data line shows the inverse of its last driven bit
  always @(posedge clock_i) if (so_oe) so_last <= so;
  assign so_line = so_oe ? so : ~so_last;
  always @(posedge clock_i or posedge rst_i) since_rst <= rst_i ? 0 : since_rst + 1;
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wait_for(input int sel, input logic lvl, output int k);
    k = 0;
    while ((sel == 0 ? busy : sel == 1 ? asleep : locked) !== lvl) begin
      host.tick(1);
      k++;
      if (k > 5000) begin
        chk("wait", 16'h0, 16'h1);
        close_out();
      end
    end
  endtask
  task automatic t_power_up();
    chk("locked", 1, locked);
    chk("asleep", 0, asleep);
    host.frame(2, 16'h0500, rx);
    chk("status", 8'h00, rx[7:0]);
    host.frame(5, {8'h03, 24'h07fff0, 8'h00}, rx);
    chk("blank", 8'hff, rx[7:0]);
    host.frame(1, 8'h06, rx);
    host.frame(4, {8'h20, 24'h0}, rx);
    chk("locked busy", 0, busy);
    host.frame(2, 16'h0500, rx);
    chk("locked latch", 8'h00, rx[7:0]);
    wait_for(2, 0, n);
    chk_rng("lockout", LK - 1, LK + 4, since_rst);
  endtask
  task automatic cycle_len(input string nm, input int cyc);
    wait_for(0, 1, n);
    wait_for(0, 0, n);
    chk_rng(nm, cyc, cyc + 16, n + 10);
  endtask
  task automatic t_erase(input logic [7:0] op, input int na, input int cyc);
    host.frame(1, 8'h06, rx);
    host.frame(5, {8'h02, 24'h012345, 8'h00}, rx);
    cycle_len("program", PG);
    host.frame(6, {8'h0b, 24'h012345, 16'h0}, rx);
    chk("programmed", 8'h00, rx[7:0]);
    host.frame(1, 8'h06, rx);
    host.frame(na, na == 1 ? 48'(op) : 48'({op, 24'h012345}), rx);
    cycle_len("erase", cyc);
    host.frame(5, {8'h03, 24'h012345, 8'h00}, rx);
    chk("erased", 8'hff, rx[7:0]);
  endtask
  task automatic t_id();
    for (int a = 0; a < 2; a++) begin
      host.frame(6, {8'h90, 24'(a), 16'h0}, rx);
      chk("id order", a ? {DEVICE_CODE, MAKER_CODE} : {MAKER_CODE, DEVICE_CODE}, rx);
    end
  endtask
  task automatic t_sleep();
    host.frame(1, 8'hb9, rx);
    wait_for(1, 1, n);
    chk_rng("sleep entry", 0, 50, n);
    host.frame(1, 8'hab, rx);
    wait_for(1, 0, n);
    chk_rng("wake plain", 0, 50, n);
    host.frame(1, 8'hb9, rx);
    wait_for(1, 1, n);
    host.frame(5, {8'hab, 24'h0, 8'h00}, rx);
    chk("signature", DEVICE_CODE, rx[7:0]);
    wait_for(1, 0, n);
    chk_rng("wake signature", 0, 26, n);
  endtask
  task automatic t_status();
    host.frame(1, 8'h06, rx);
    host.frame(2, 16'h01ff, rx);
    cycle_len("status write", ST);
    host.frame(2, 16'h0500, rx);
    chk("status", 8'hff & STATUS_WMASK, rx[7:0]);
  endtask
  initial begin
    num_errors = 0;
    n_tests = 0;
    so_last = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #2 rst_i = 1'b0;
    host.tick(200);
    t_power_up();
    t_erase(8'h20, 4, SE);
    t_erase(8'h52, 4, BE);
    t_erase(8'hd8, 4, BE);
    t_erase(8'h60, 1, CE);
    t_erase(8'hc7, 1, CE);
    t_id();
    t_sleep();
    t_status();
    close_out();
  end
endmodule
